// ---- core/cu_compare_unit.sv ----
// compare unit, 16-bit timer, interrupt status and AXI4-Lite register slave
// assumes synchronous inputs on aclk; core_literal and core_opcode_msb come from the core each cycle
`timescale 1ns/1ns
module cu_compare_unit
  import cu_pkg::*;
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [7:0] core_literal, // literal field of current instruction
  input wire logic core_opcode_msb, // msb of current instruction
  output logic compare_pin, // compare output pin level
  output logic compare_pin_oe, // pin driven by compare unit
  output logic adc_start, // special event conversion start pulse
  output logic irq // level interrupt
);

  // ************************************************************
  // write channel
  // ************************************************************
  logic aw_full;
  logic w_full;
  logic [5:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_go;
  logic wr_mapped;

  assign wr_go = aw_full && w_full && !bvalid;
  assign wr_mapped = wr_idx inside {IDX_CMP_LO, IDX_CMP_HI, IDX_CTRL, IDX_IRQ_STATUS,
                                    IDX_IRQ_MASK, IDX_TMR_LO, IDX_TMR_HI, IDX_TMR_CTRL};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      awready <= 1'b1;
      wr_idx <= 6'h00;
    end
    else if (awvalid && awready)
    begin
      aw_full <= 1'b1;
      awready <= 1'b0;
      wr_idx <= awaddr[7:2];
    end
    else if (wr_go)
      aw_full <= 1'b0;
    else if (bvalid && bready)
      awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      wready <= 1'b1;
      wr_byte <= RST_BYTE;
      wr_lane <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_full <= 1'b1;
      wready <= 1'b0;
      wr_byte <= wdata[7:0];
      wr_lane <= wstrb[0];
    end
    else if (wr_go)
      w_full <= 1'b0;
    else if (bvalid && bready)
      wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  logic wr_en;
  logic ctrl_wr;
  logic tlo_wr;
  logic thi_wr;
  assign wr_en = wr_go && wr_lane;
  assign ctrl_wr = wr_en && (wr_idx == IDX_CTRL);
  assign tlo_wr = wr_en && (wr_idx == IDX_TMR_LO);
  assign thi_wr = wr_en && (wr_idx == IDX_TMR_HI);

  // ************************************************************
  // plain registers
  // ************************************************************
  logic [7:0] cmp_lo;
  logic [7:0] cmp_hi;
  logic [7:0] ctrl;
  logic [1:0] irq_mask;
  logic run;
  logic [3:0] mode;
  assign mode = ctrl[3:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_lo <= RST_BYTE;
      cmp_hi <= RST_BYTE;
      ctrl <= RST_BYTE;
      irq_mask <= RST_IRQ;
      run <= 1'b0;
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_CMP_LO)
        cmp_lo <= wr_byte;
      if (wr_idx == IDX_CMP_HI)
        cmp_hi <= wr_byte;
      if (wr_idx == IDX_CTRL)
        ctrl <= wr_byte;
      if (wr_idx == IDX_IRQ_MASK)
        irq_mask <= wr_byte[1:0];
      if (wr_idx == IDX_TMR_CTRL)
        run <= wr_byte[RUN_BIT];
    end
  end

  // ************************************************************
  // timer, match and trigger
  // ************************************************************
  logic [15:0] timer;
  logic run_d;
  logic off_after_run;
  logic armed_ff;
  logic match;
  logic prev_hit;
  logic suppress;
  logic trig;
  logic ovf;

  assign match = run && (timer == {cmp_hi, cmp_lo}) && (mode[3:2] == 2'b10);
  assign suppress = prev_hit && !core_opcode_msb;
  assign trig = match && (mode == CU_MODE_TRIGGER) && !suppress;
  assign ovf = run && (timer == 16'hffff) && !trig && !tlo_wr && !thi_wr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_hit <= 1'b0;
    else
      prev_hit <= core_literal inside {LIT_CMP_LO, LIT_CMP_HI, LIT_CTRL};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_d <= 1'b0;
      off_after_run <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      run_d <= run;
      if (run)
      begin
        off_after_run <= 1'b0;
        armed_ff <= 1'b0;
      end
      else if (run_d)
      begin
        off_after_run <= 1'b1;
        armed_ff <= (timer[7:0] == 8'hff);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer <= RST_TIMER;
    else if (trig)
      timer <= RST_TIMER;
    else if (tlo_wr)
    begin
      timer[7:0] <= wr_byte;
      if (armed_ff && !run)
        timer[15:8] <= 8'(timer[15:8] + 8'h01);
    end
    else if (thi_wr)
    begin
      timer[15:8] <= wr_byte;
      if (off_after_run && !run)
        timer[7:0] <= 8'(timer[7:0] + 8'h01);
    end
    else if (run)
      timer <= 16'(timer + 16'h0001);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_start <= 1'b0;
    else
      adc_start <= trig;
  end

  // ************************************************************
  // compare pin
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_pin <= 1'b0;
    else if (ctrl_wr)
    begin
      if (wr_byte[3:0] == CU_MODE_DRIVE_LOW)
        compare_pin <= (mode == CU_MODE_DRIVE_HIGH) ? compare_pin : 1'b0;
      else if (wr_byte[3:0] == CU_MODE_DRIVE_HIGH)
        compare_pin <= (mode == CU_MODE_DRIVE_HIGH) ? compare_pin : 1'b0;
    end
    else if (match && (mode == CU_MODE_DRIVE_HIGH))
      compare_pin <= 1'b1;
    else if (match && (mode == CU_MODE_DRIVE_LOW))
      compare_pin <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_pin_oe <= 1'b0;
    else
      compare_pin_oe <= (mode[3:1] == 3'b100);
  end

  // ************************************************************
  // interrupt status, write one to clear, set wins
  // ************************************************************
  logic [1:0] irq_status;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] next_status;

  assign irq_set = {ovf, match};
  assign irq_clr = (wr_en && wr_idx == IDX_IRQ_STATUS) ? wr_byte[1:0] : 2'h0;
  assign next_status = (irq_status & ~irq_clr) | irq_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= RST_IRQ;
    else
      irq_status <= next_status;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_ok;
  assign rd_idx = araddr[7:2];

  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    unique case (rd_idx)
      IDX_CMP_LO: rd_byte = cmp_lo;
      IDX_CMP_HI: rd_byte = cmp_hi;
      IDX_CTRL: rd_byte = ctrl;
      IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      IDX_TMR_LO: rd_byte = timer[7:0];
      IDX_TMR_HI: rd_byte = timer[15:8];
      IDX_TMR_CTRL: rd_byte = {7'h00, run};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_low_entry_pin: assert property (
    ctrl_wr && wr_byte[3:0] == CU_MODE_DRIVE_LOW && mode != CU_MODE_DRIVE_HIGH |=> !compare_pin)
    else $error("pin not low after entering drive-low mode");

  a_high_entry_pin: assert property (
    ctrl_wr && wr_byte[3:0] == CU_MODE_DRIVE_HIGH && mode != CU_MODE_DRIVE_HIGH |=> !compare_pin)
    else $error("pin not low after entering drive-high mode");

  a_high_match_pin: assert property (
    match && mode == CU_MODE_DRIVE_HIGH && !ctrl_wr |=> compare_pin ##1 compare_pin || $changed(ctrl))
    else $error("pin not high after drive-high match");

  a_keep_on_swap: assert property (
    ctrl_wr && wr_byte[3:0] == CU_MODE_DRIVE_LOW && mode == CU_MODE_DRIVE_HIGH
    |=> compare_pin == $past(compare_pin))
    else $error("pin level lost on high to low mode change");

  a_trig_masked: assert property (
    match && mode == CU_MODE_TRIGGER && prev_hit && !core_opcode_msb |=> !adc_start)
    else $error("trigger not suppressed");

  a_trig_clears: assert property (
    match && mode == CU_MODE_TRIGGER && !suppress |=> adc_start && timer == RST_TIMER)
    else $error("trigger did not clear timer");

  a_flag_on_match: assert property (
    match |=> irq_status[ST_CMP])
    else $error("compare flag not raised");

  a_low_bump: assert property (
    thi_wr && off_after_run && !run && !trig |=> timer[7:0] == 8'($past(timer[7:0]) + 8'h01))
    else $error("low byte not bumped");

  a_high_bump: assert property (
    tlo_wr && armed_ff && !run && !trig && !irq_status[ST_OVF]
    |=> timer[15:8] == 8'($past(timer[15:8]) + 8'h01) && !irq_status[ST_OVF])
    else $error("high byte not bumped or overflow set");

  a_timer_counts: assert property (
    run && !trig && !tlo_wr && !thi_wr |=> timer == 16'($past(timer) + 16'h0001))
    else $error("timer did not count");

  c_trig_fire: cover property (trig ##1 adc_start);
  c_trig_masked: cover property (match && mode == CU_MODE_TRIGGER && suppress);
  c_low_bump: cover property (thi_wr && off_after_run && !run);
  c_pin_high: cover property (match && mode == CU_MODE_DRIVE_HIGH ##1 compare_pin);

endmodule

// ---- core/cu_pkg.sv ----
// constants for the compare unit with its 16-bit timer and register slave
// assumes one 100 MHz clock and a processor core feeding instruction info
package cu_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_CMP_LO = 6'h15;
  localparam logic [5:0] IDX_CMP_HI = 6'h16;
  localparam logic [5:0] IDX_CTRL = 6'h17;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h0c;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0d;
  localparam logic [5:0] IDX_TMR_LO = 6'h0e;
  localparam logic [5:0] IDX_TMR_HI = 6'h0f;
  localparam logic [5:0] IDX_TMR_CTRL = 6'h10;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int RUN_BIT = 0;
  localparam int ST_CMP = 0;
  localparam int ST_OVF = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [15:0] RST_TIMER = 16'h0000;

  // ************************************************************
  // compare mode codes
  // ************************************************************
  typedef enum logic [3:0] {
    CU_MODE_OFF = 4'h0,
    CU_MODE_DRIVE_HIGH = 4'h8,
    CU_MODE_DRIVE_LOW = 4'h9,
    CU_MODE_SOFT_IRQ = 4'ha,
    CU_MODE_TRIGGER = 4'hb
  } cu_mode_e;

  // ************************************************************
  // literal values that can mask the special event trigger
  // ************************************************************
  localparam logic [7:0] LIT_CMP_LO = 8'h15;
  localparam logic [7:0] LIT_CMP_HI = 8'h16;
  localparam logic [7:0] LIT_CTRL = 8'h17;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- tb/cu_core_model.sv ----
// core model: issues one instruction per cycle to the compare unit
// assumes the bench picks the literal and msb of the stream
`timescale 1ns/1ns
module cu_core_model
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] pat_literal, // literal of next instruction
  input wire logic pat_msb, // msb of next instruction
  output logic [7:0] core_literal, // literal executing now
  output logic core_opcode_msb // msb executing now
);
  // an address literal then an msb-clear opcode can mask the trigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_literal <= 8'h00;
      core_opcode_msb <= 1'b1;
    end
    else
    begin
      core_literal <= pat_literal;
      core_opcode_msb <= pat_msb;
    end
  end
endmodule

// ---- tb/tb_cu_compare_unit.sv ----
// bench for the compare unit: register access, pin modes, trigger masking, timer writes
// assumes the unit answers its register bus within 100 cycles
`timescale 1ns/1ns
module tb_cu_compare_unit
  import cu_pkg::*;
();
  logic aclk = 1'b0, aresetn = 1'b0, pat_msb = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pat_literal = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, compare_pin, compare_pin_oe, adc_start, irq, core_opcode_msb;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [7:0] core_literal, rd, n;
  logic [5:0] regs [8] = '{IDX_CMP_LO, IDX_CMP_HI, IDX_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_TMR_LO,
    IDX_TMR_HI, IDX_TMR_CTRL};
  logic [7:0] from_modes [3] = '{8'h00, 8'h0a, 8'h0c};
  int fail_count = 0, check_count = 0, trig_count = 0, t0;

  always #5 aclk = ~aclk;
  always @(posedge aclk)
    if (adc_start === 1'b1)
      trig_count <= trig_count + 1;

  cu_compare_unit uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .core_literal(core_literal), .core_opcode_msb(core_opcode_msb),
    .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe), .adc_start(adc_start), .irq(irq));
  cu_core_model u_core (.aclk(aclk), .aresetn(aresetn), .pat_literal(pat_literal), .pat_msb(pat_msb),
    .core_literal(core_literal), .core_opcode_msb(core_opcode_msb));

  // ********************
  // report and compare
  // ********************
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    fail_count++;
    $display("[FAIL] %0t ns: wait ran out", $time);
    finish_test();
  endtask

  // ********************
  // register bus master
  // ********************
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bit done = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rsp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
      hang();
  endtask

  task automatic rdr(input logic [5:0] idx);
    bit done = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rd = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
      hang();
  endtask

  // ********************
  // scenario helpers
  // ********************
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic wait_pin(input logic lvl);
    int i;
    for (i = 0; i < 300 && compare_pin !== lvl; i++)
      @(posedge aclk);
    if (i == 300)
      hang();
  endtask

  // force a drive-high match so the pin starts high
  task automatic hit_high();
    wr(IDX_CTRL, 8'h08);
    wr(IDX_TMR_LO, 8'h30);
    wr(IDX_TMR_HI, 8'h00);
    wait_pin(1'b1);
  endtask

  task automatic trig_case(input logic [7:0] lit, input logic msb, input int exp);
    bit seen = 0;
    pat_literal <= lit;
    pat_msb <= msb;
    wr(IDX_TMR_LO, 8'h30);
    wr(IDX_TMR_HI, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h03);
    t0 = trig_count;
    for (int i = 0; i < 30 && !seen; i++)
    begin
      rdr(IDX_IRQ_STATUS);
      seen = rd[ST_CMP];
    end
    repeat (3) @(posedge aclk);
    check({7'h0, seen}, 8'h01);
    check(8'(trig_count - t0), 8'(exp));
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i])
    begin
      rdr(regs[i]);
      check(rd, RST_BYTE);
    end
    rdr(6'h3f);
    check({6'h0, rsp}, {6'h0, RESP_SLVERR});
    wr(6'h3e, 8'h5a);
    check({6'h0, rsp}, {6'h0, RESP_SLVERR});
    wr(IDX_CMP_LO, 8'h40);
    rdr(IDX_CMP_LO);
    check(rd, 8'h40);
    wr(IDX_TMR_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h08);
    // oe follows the stored mode one cycle later
    @(posedge aclk);
    check({6'h0, compare_pin_oe, compare_pin}, 8'h02);
    hit_high();
    rdr(IDX_IRQ_STATUS);
    check(rd, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(IDX_IRQ_MASK, 8'h03);
    repeat (2) @(posedge aclk);
    check({7'h0, irq}, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    check({7'h0, irq}, 8'h00);
    wr(IDX_CTRL, 8'h09);
    check({7'h0, compare_pin}, 8'h01);
    wr(IDX_TMR_LO, 8'h30);
    wr(IDX_TMR_HI, 8'h00);
    wait_pin(1'b0);
    hit_high();
    wr(IDX_CTRL, 8'h09);
    wr(IDX_CTRL, 8'h08);
    check({7'h0, compare_pin}, 8'h00);
    foreach (from_modes[f])
      for (int t = 8; t < 10; t++)
      begin
        hit_high();
        wr(IDX_CTRL, from_modes[f]);
        @(posedge aclk);
        check({7'h0, compare_pin_oe}, 8'h00);
        wr(IDX_CTRL, 8'(t));
        @(posedge aclk);
        check({6'h0, compare_pin_oe, compare_pin}, 8'h02);
      end
    wr(IDX_CTRL, 8'h0b);
    trig_case(8'h00, 1'b0, 1);
    trig_case(LIT_CMP_LO, 1'b0, 0);
    trig_case(LIT_CMP_HI, 1'b0, 0);
    trig_case(LIT_CTRL, 1'b0, 0);
    trig_case(LIT_CMP_LO, 1'b1, 1);
    do_reset();
    wr(IDX_TMR_LO, 8'hf0);
    wr(IDX_TMR_HI, 8'h12);
    wr(IDX_TMR_CTRL, 8'h01);
    wr(IDX_TMR_CTRL, 8'h00);
    rdr(IDX_TMR_LO);
    n = rd - 8'hf0;
    wr(IDX_TMR_HI, 8'h3f);
    rdr(IDX_TMR_LO);
    check(rd, 8'hf1 + n);
    rdr(IDX_TMR_HI);
    check(rd, 8'h3f);
    // shadow write-back: high byte first, then low byte restores the copy
    wr(IDX_TMR_HI, 8'h3f);
    wr(IDX_TMR_LO, 8'hf1 + n);
    rdr(IDX_TMR_LO);
    check(rd, 8'hf1 + n);
    rdr(IDX_TMR_HI);
    check(rd, 8'h3f);
    do_reset();
    wr(IDX_TMR_LO, 8'hff - n);
    wr(IDX_TMR_HI, 8'hff);
    wr(IDX_TMR_CTRL, 8'h01);
    wr(IDX_TMR_CTRL, 8'h00);
    wr(IDX_TMR_LO, 8'h00);
    rdr(IDX_TMR_HI);
    check(rd, 8'h00);
    rdr(IDX_IRQ_STATUS);
    check(rd, 8'h00);
    finish_test();
  end
endmodule
